// File: far_station.sv
/* Remote serial station: sends frames on rxd, captures frames from txd.
   Assumes calls start just after a rising edge of mclk. */
module far_station (
  // Clock
  input wire logic mclk,
  // Serial line
  input wire logic txd,
  output     logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Frame tasks
  // ----
  initial rxd = 1'b1;
  task automatic send(input logic [10:0] f, input int n, input int bt);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (bt) @(posedge mclk);
    end
    rxd <= 1'b1;
  endtask
  // Samples mid-bit so a phase slip of under half a bit still reads right
  task automatic grab(output logic [10:0] f, input int n, input int bt);
    int w;
    f = 11'h0;
    w = 0;
    while (txd !== 1'b0 && w < 4000) begin
      @(posedge mclk);
      w++;
    end
    repeat (bt / 2) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (bt) @(posedge mclk);
    end
  endtask
endmodule

// File: serial_port.sv
/*
  Asynchronous serial port with a ten-bit mode and two eleven-bit modes,
  register access over a classic Wishbone slave. Assumes rxd is already
  synchronous to mclk and that the bus master follows classic cycles.
*/
module serial_port (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // Register bus
  input  wire uart9_pkg::wb_req_t wb_req,
  output      uart9_pkg::wb_rsp_t wb_rsp,
  // Serial line
  input  wire logic               rxd,
  output      logic               txd,
  // Interrupt request
  output      logic               serial_irq
);
  import uart9_pkg::*;

  typedef struct packed {
    wb_rsp_t    rsp;
    logic [1:0] mode;
    logic       filter;
    logic       rx_en;
    logic       tx_ninth;
    logic       rx_ninth;
    logic       tx_flag;
    logic       rx_flag;
    logic [7:0] reload;
    logic       half;
    logic [7:0] rate_cnt;
    logic       half_tgl;
    logic [3:0] tx_div;
    logic       tx_req;
    tx_state_t  tx_st;
    logic [8:0] tx_shift;
    logic       tx_shifted;
    logic       txd;
    logic       irq;
    rx_state_t  rx_st;
    logic [3:0] rx_div;
    logic [8:0] rx_shift;
    logic       rx_prev;
    logic [1:0] rx_smp;
    logic       rx_first;
    logic [7:0] rx_buf;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  assign wb_rsp     = s_r.rsp;
  assign txd        = s_r.txd;
  assign serial_irq = s_r.irq;

  always_comb begin
    logic       tick;
    logic       req;
    logic       wr;
    logic       tx_roll;
    logic       tx_set;
    logic       rx_set;
    logic       maj;
    logic       eleven;
    logic [7:0] ctl;
    tick    = 1'b0;
    req     = 1'b0;
    wr      = 1'b0;
    tx_roll = 1'b0;
    tx_set  = 1'b0;
    rx_set  = 1'b0;
    maj     = 1'b0;
    eleven  = 1'b0;
    ctl     = 8'h00;
    s_nxt   = s_r;

    // ----------------------------------------
    // Bit-rate tick at sixteen times the bit rate
    // ----------------------------------------
    case (s_r.mode)
      MODE_TEN, MODE_VAR: begin
        s_nxt.rate_cnt = s_r.rate_cnt + 8'h01;
        if (s_r.rate_cnt == RATE_TOP) begin
          s_nxt.rate_cnt = s_r.reload;
          tick = 1'b1;
        end
      end
      MODE_FIXED: begin
        // Tick every clock gives clock/16, every second clock clock/32
        s_nxt.half_tgl = ~s_r.half_tgl;
        tick = ~s_r.half | s_r.half_tgl;
      end
      default: begin
        tick = 1'b0;
      end
    endcase
    eleven = (s_r.mode == MODE_FIXED) || (s_r.mode == MODE_VAR);

    // ----------------------------------------
    // Wishbone slave: ack one cycle after request
    // ----------------------------------------
    req = wb_req.cyc & wb_req.stb & ~s_r.rsp.ack;
    wr  = req & wb_req.we;
    s_nxt.rsp.ack = req;
    s_nxt.rsp.dat = 32'h0000_0000;
    ctl[CTL_MODE_LO +: 2] = s_r.mode;
    ctl[CTL_FILTER]       = s_r.filter;
    ctl[CTL_RX_ENABLE]    = s_r.rx_en;
    ctl[CTL_TX_NINTH]     = s_r.tx_ninth;
    ctl[CTL_RX_NINTH]     = s_r.rx_ninth;
    ctl[CTL_TX_FLAG]      = s_r.tx_flag;
    ctl[CTL_RX_FLAG]      = s_r.rx_flag;
    if (req && !wb_req.we) begin
      case (wb_req.adr)
        ADDR_BUFFER:  s_nxt.rsp.dat = {24'h00_0000, s_r.rx_buf};
        ADDR_CONTROL: s_nxt.rsp.dat = {24'h00_0000, ctl};
        ADDR_RATE:    s_nxt.rsp.dat = {23'h00_0000, s_r.half, s_r.reload};
        default:      s_nxt.rsp.dat = 32'h0000_0000;
      endcase
    end
    if (wr && wb_req.sel[0] && wb_req.adr == ADDR_CONTROL) begin
      s_nxt.mode     = wb_req.dat[CTL_MODE_LO +: 2];
      s_nxt.filter   = wb_req.dat[CTL_FILTER];
      s_nxt.rx_en    = wb_req.dat[CTL_RX_ENABLE];
      s_nxt.tx_ninth = wb_req.dat[CTL_TX_NINTH];
      s_nxt.rx_ninth = wb_req.dat[CTL_RX_NINTH];
      s_nxt.tx_flag  = wb_req.dat[CTL_TX_FLAG];
      s_nxt.rx_flag  = wb_req.dat[CTL_RX_FLAG];
    end
    if (wr && wb_req.sel[0] && wb_req.adr == ADDR_RATE) begin
      s_nxt.reload = wb_req.dat[RATE_RELOAD_LO +: 8];
    end
    if (wr && wb_req.sel[1] && wb_req.adr == ADDR_RATE) begin
      s_nxt.half = wb_req.dat[RATE_HALF];
    end
    // Writes while a frame is pending or in flight are dropped, not queued
    if (wr && wb_req.sel[0] && wb_req.adr == ADDR_BUFFER && !s_r.tx_req &&
        s_r.tx_st == TX_IDLE && s_r.mode != MODE_SHIFT) begin
      s_nxt.tx_shift   = {(eleven ? s_r.tx_ninth : 1'b1), wb_req.dat[7:0]};
      s_nxt.tx_req     = 1'b1;
      s_nxt.tx_shifted = 1'b0;
    end

    // ----------------------------------------
    // Transmitter, stepped by divide-by-16 rollovers
    // ----------------------------------------
    if (tick) begin
      s_nxt.tx_div = s_r.tx_div + 4'h1;
    end
    tx_roll = tick && (s_r.tx_div == DIV_LAST);
    if (tx_roll) begin
      case (s_r.tx_st)
        TX_IDLE: begin
          if (s_r.tx_req) begin
            s_nxt.tx_st  = TX_START;
            s_nxt.tx_req = 1'b0;
          end
        end
        TX_START: begin
          s_nxt.tx_st = TX_DATA;
        end
        TX_DATA: begin
          if (s_r.tx_shifted && s_r.tx_shift[8:1] == TX_END_MARK) begin
            s_nxt.tx_st = TX_IDLE;
            tx_set      = 1'b1;
          end
          // Eleven-bit modes insert the stop one on the first shift only
          s_nxt.tx_shift   = {(eleven && !s_r.tx_shifted), s_r.tx_shift[8:1]};
          s_nxt.tx_shifted = 1'b1;
        end
        default: begin
          s_nxt.tx_st = TX_IDLE;
        end
      endcase
    end
    case (s_nxt.tx_st)
      TX_START: s_nxt.txd = 1'b0;
      TX_DATA:  s_nxt.txd = s_nxt.tx_shift[0];
      default:  s_nxt.txd = 1'b1;
    endcase

    // ----------------------------------------
    // Receiver, sampled at sixteen times the bit rate
    // ----------------------------------------
    if (tick) begin
      case (s_r.rx_st)
        RX_IDLE: begin
          s_nxt.rx_prev = rxd;
          if (s_r.rx_en && s_r.rx_prev && !rxd) begin
            s_nxt.rx_st    = RX_BITS;
            s_nxt.rx_div   = 4'h0;
            s_nxt.rx_shift = RX_SHIFT_INIT;
            s_nxt.rx_first = 1'b1;
          end
        end
        RX_BITS: begin
          s_nxt.rx_div = s_r.rx_div + 4'h1;
          if (s_r.rx_div == SAMPLE_FIRST || s_r.rx_div == SAMPLE_MID) begin
            s_nxt.rx_smp = {s_r.rx_smp[0], rxd};
          end
          if (s_r.rx_div == SAMPLE_LAST) begin
            maj = (s_r.rx_smp[1] & s_r.rx_smp[0]) | (s_r.rx_smp[1] & rxd) |
                  (s_r.rx_smp[0] & rxd);
            s_nxt.rx_first = 1'b0;
            s_nxt.rx_shift = {maj, s_r.rx_shift[8:1]};
            if (s_r.rx_first && maj) begin
              s_nxt.rx_st   = RX_IDLE;
              s_nxt.rx_prev = rxd;
            end else if (!s_r.rx_shift[0]) begin
              // Start bit at the far end: this is the last shift
              if (!s_r.rx_flag && (!s_r.filter || maj)) begin
                s_nxt.rx_buf   = s_r.rx_shift[8:1];
                s_nxt.rx_ninth = maj;
                rx_set         = 1'b1;
              end
              if (eleven) begin
                s_nxt.rx_st = RX_STOP;
              end else begin
                s_nxt.rx_st   = RX_IDLE;
                s_nxt.rx_prev = rxd;
              end
            end
          end
        end
        RX_STOP: begin
          s_nxt.rx_div = s_r.rx_div + 4'h1;
          if (s_r.rx_div == SAMPLE_LAST) begin
            s_nxt.rx_st   = RX_IDLE;
            s_nxt.rx_prev = rxd;
          end
        end
        default: begin
          s_nxt.rx_st = RX_IDLE;
        end
      endcase
    end

    // ----------------------------------------
    // Sticky flags: hardware set wins over a software clear
    // ----------------------------------------
    s_nxt.tx_flag = s_nxt.tx_flag | tx_set;
    s_nxt.rx_flag = s_nxt.rx_flag | rx_set;
    s_nxt.irq     = s_nxt.tx_flag | s_nxt.rx_flag;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r         <= '0;
      s_r.mode    <= MODE_RESET;
      s_r.reload  <= RELOAD_RESET;
      s_r.txd     <= 1'b1;
      s_r.rx_prev <= 1'b1;
      s_r.tx_st   <= TX_IDLE;
      s_r.rx_st   <= RX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// File: serial_port_asserts.sv
/* Checker for the serial port bus and line ports.
   Assumes all ports move on the rising edge of mclk. */
module serial_port_asserts (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               rst_n,
  // Watched ports
  input wire uart9_pkg::wb_req_t wb_req,
  input wire uart9_pkg::wb_rsp_t wb_rsp,
  input wire logic               rxd,
  input wire logic               txd,
  input wire logic               serial_irq
);
  import uart9_pkg::*;
  // ----
  // Bus and line properties
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire req    = wb_req.cyc && wb_req.stb;
  wire rd_ctl = req && !wb_req.we && wb_req.adr == ADDR_CONTROL;
  wire mapped = wb_req.adr inside {ADDR_BUFFER, ADDR_CONTROL, ADDR_RATE};
  a_ack_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack held too long");
  a_ack_answer: assert property (req && !wb_rsp.ack |=> wb_rsp.ack) else $error("request not answered");
  a_no_spurious: assert property (!req |=> !wb_rsp.ack) else $error("ack without request");
  a_upper_zero: assert property (wb_rsp.ack |-> wb_rsp.dat[31:9] == 23'h0) else $error("upper bits set");
  a_unmapped_zero: assert property (wb_rsp.ack && !mapped |-> wb_rsp.dat == 32'h0) else $error("unmapped data");
  a_irq_flags: assert property (wb_rsp.ack && rd_ctl |-> $past(serial_irq) == |wb_rsp.dat[1:0])
    else $error("irq does not match flags");
  a_irq_sticky: assert property ($fell(serial_irq) |-> $past(wb_req.cyc && wb_req.we))
    else $error("flag dropped without write");
  a_reset_idle: assert property (disable iff (1'b0) !rst_n |=> txd && !serial_irq && !wb_rsp.ack)
    else $error("outputs not idle in reset");
  a_start_hold: assert property ($fell(txd) |-> !txd [*8]) else $error("start bit too short");
  a_high_hold: assert property ($rose(txd) |-> txd [*8]) else $error("high bit too short");
  c_rx_flag: cover property (rd_ctl && wb_rsp.ack && wb_rsp.dat[0]);
  c_tx_start: cover property ($fell(txd));
  c_irq_up: cover property ($rose(serial_irq));
endmodule
bind serial_port serial_port_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
  .rxd(rxd), .txd(txd), .serial_irq(serial_irq));

// File: serial_port_bench.sv
/* Self-checking bench for the serial port.
   Assumes the far station model and the bound checker. */
module serial_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import uart9_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  wb_req_t     req;
  wb_rsp_t     rsp;
  logic        rxd;
  logic        txd;
  logic        irq;
  int          n_errors = 0;
  int          samples_checked = 0;
  logic [31:0] rd;
  logic [10:0] fr;
  always #4 mclk = ~mclk;
  serial_port u_dut (.mclk(mclk), .rst_n(rst_n), .wb_req(req), .wb_rsp(rsp), .rxd(rxd), .txd(txd),
    .serial_irq(irq));
  far_station u_far (.mclk(mclk), .txd(txd), .rxd(rxd));
  // ----
  // Access and compare tasks
  // ----
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    @(posedge mclk);
    // No cycle count assumed; only the watchdog ends a stuck wait
    while (rsp.ack !== 1'b1) begin
      @(posedge mclk);
    end
    q = rsp.dat;
    req <= '0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask
  function automatic logic [10:0] frm(input logic [7:0] d, input logic n9, input logic el);
    return el ? {1'b1, n9, d, 1'b0} : {2'b01, d, 1'b0};
  endfunction
  task automatic summarize;
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    req = '0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk({31'h0, txd}, 32'h1);
    bus(1'b0, ADDR_CONTROL, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, 4'hc, 32'h0, rd);
    chk(rd, 32'h0);
    // Reload ff gives a 16 clock bit time
    wr(ADDR_RATE, 32'h0ff);
    wr(ADDR_CONTROL, 32'h50);
    fork
      u_far.grab(fr, 10, 16);
      wr(ADDR_BUFFER, 32'ha5);
    join
    chk({21'h0, fr}, {21'h0, frm(8'ha5, 1'b0, 1'b0)});
    bus(1'b0, ADDR_CONTROL, 32'h0, rd);
    chk(rd, 32'h52);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_CONTROL, 32'h50);
    u_far.send(frm(8'h3c, 1'b0, 1'b0), 10, 16);
    bus(1'b0, ADDR_BUFFER, 32'h0, rd);
    chk(rd, 32'h3c);
    bus(1'b0, ADDR_CONTROL, 32'h0, rd);
    chk(rd, 32'h55);
    u_far.send(frm(8'hc3, 1'b0, 1'b0), 10, 16);
    bus(1'b0, ADDR_BUFFER, 32'h0, rd);
    chk(rd, 32'h3c);
    wr(ADDR_CONTROL, 32'h74);
    u_far.send({3'h0, 8'h99, 1'b0}, 10, 16);
    bus(1'b0, ADDR_CONTROL, 32'h0, rd);
    chk(rd, 32'h74);
    u_far.send(11'h0, 1, 4);
    repeat (40) @(posedge mclk);
    u_far.send(frm(8'h81, 1'b0, 1'b0), 10, 16);
    bus(1'b0, ADDR_BUFFER, 32'h0, rd);
    chk(rd, 32'h81);
    wr(ADDR_CONTROL, 32'hd4);
    fork
      u_far.grab(fr, 11, 16);
      wr(ADDR_BUFFER, 32'h5a);
    join
    chk({21'h0, fr}, {21'h0, frm(8'h5a, 1'b0, 1'b1)});
    // Half bit set: 32 clocks a bit in the fixed-rate mode
    wr(ADDR_RATE, 32'h1ff);
    wr(ADDR_CONTROL, 32'h9c);
    fork
      u_far.grab(fr, 11, 32);
      wr(ADDR_BUFFER, 32'h96);
    join
    chk({21'h0, fr}, {21'h0, frm(8'h96, 1'b1, 1'b1)});
    wr(ADDR_CONTROL, 32'hbc);
    u_far.send(frm(8'h11, 1'b0, 1'b1), 11, 32);
    repeat (64) @(posedge mclk);
    bus(1'b0, ADDR_CONTROL, 32'h0, rd);
    chk(rd, 32'hbc);
    u_far.send(frm(8'h4e, 1'b1, 1'b1), 11, 32);
    bus(1'b0, ADDR_BUFFER, 32'h0, rd);
    chk(rd, 32'h4e);
    bus(1'b0, ADDR_CONTROL, 32'h0, rd);
    chk(rd, 32'hbd);
    // Half bit clear: 16 clocks a bit in the fixed-rate mode
    wr(ADDR_RATE, 32'h0ff);
    wr(ADDR_CONTROL, 32'h94);
    fork
      u_far.grab(fr, 11, 16);
      wr(ADDR_BUFFER, 32'h3b);
    join
    chk({21'h0, fr}, {21'h0, frm(8'h3b, 1'b0, 1'b1)});
    wr(ADDR_CONTROL, 32'hd0);
    u_far.send(frm(8'h27, 1'b0, 1'b1), 11, 16);
    bus(1'b0, ADDR_BUFFER, 32'h0, rd);
    chk(rd, 32'h27);
    bus(1'b0, ADDR_CONTROL, 32'h0, rd);
    chk(rd, 32'hd1);
    summarize;
  end
  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    summarize;
  end
endmodule

// File: uart9_pkg.sv
/*
  Constants, register layout and carrier types for the nine-bit capable
  asynchronous serial port. Assumes a classic Wishbone master with 32-bit
  data and a byte address of which the low four bits reach the block.
*/
// Behaviour
// - Ten-bit frame: low start, eight data bits LSB first, high stop.
// - Ten-bit mode stores the received stop bit as received ninth bit.
// - Ten-bit mode bit rate comes from rate timer overflows.
// - Buffer write requests transmit; ten-bit mode loads one into ninth position.
// - Transmit starts just after next divide-by-16 rollover, bit times follow counter.
// - Start bit first, shift output one bit later, first shift one bit after.
// - Zeros enter left; marker pattern ends frame and sets done at tenth rollover.
// - Eleven-bit modes load ninth bit value; first shift inserts stop one.
// - Eleven-bit modes end transmit and set done at eleventh rollover.
// - Sample line at 16x; falling edge resets counter, loads all ones.
// - Samples at counter states 7, 8 and 9; majority decides the bit.
// - A non-zero first bit aborts reception and resumes edge search.
// - Nine-bit receive register; start bit at end triggers last shift, load.
// - Ten-bit load needs done flag clear and filter off or stop one.
// - Ten-bit receiver always returns to edge search after final shift.
// - Eleven-bit frame: start, eight data LSB first, ninth bit, stop.
// - Fixed-rate eleven-bit mode runs at clock/16 or clock/32.
// - Variable-rate eleven-bit mode uses rate timer overflows.
// - Eleven-bit accept needs done flag clear and filter off or ninth one.
// - Accepted eleven-bit frame loads ninth bit, data byte, sets done flag.
// - Eleven-bit receiver resumes edge search one bit time after final shift.
package uart9_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] ADDR_BUFFER  = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_RATE    = 4'h8;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTL_RX_FLAG   = 0;
  localparam int CTL_TX_FLAG   = 1;
  localparam int CTL_RX_NINTH  = 2;
  localparam int CTL_TX_NINTH  = 3;
  localparam int CTL_RX_ENABLE = 4;
  localparam int CTL_FILTER    = 5;
  localparam int CTL_MODE_LO   = 6;

  // Rate register fields
  localparam int RATE_RELOAD_LO = 0;
  localparam int RATE_HALF      = 8;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [1:0] MODE_RESET   = 2'h0;
  localparam logic [7:0] RELOAD_RESET = 8'h00;

  // ----------------------------------------
  // Modes and timing counts
  // ----------------------------------------
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_TEN   = 2'h1;
  localparam logic [1:0] MODE_FIXED = 2'h2;
  localparam logic [1:0] MODE_VAR   = 2'h3;

  localparam logic [7:0] RATE_TOP      = 8'hff;
  localparam logic [3:0] DIV_LAST      = 4'hf;
  localparam logic [3:0] SAMPLE_FIRST  = 4'h7;
  localparam logic [3:0] SAMPLE_MID    = 4'h8;
  localparam logic [3:0] SAMPLE_LAST   = 4'h9;
  localparam logic [8:0] RX_SHIFT_INIT = 9'h1ff;
  localparam logic [7:0] TX_END_MARK   = 8'h01;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_STOP} rx_state_t;

endpackage
